// ### rtl/sws_slave.sv
`timescale 1ns/100ps
`default_nettype none
`include "sws_regs.svh"

module sws_slave
  import sws_pkg::*;
#(
  parameter int RST_STD_CYC = `SWS_RST_STD_CYC,
  parameter int RST_OD_CYC  = `SWS_RST_OD_CYC,
  parameter int OD_EXIT_CYC = `SWS_OD_EXIT_CYC,
  parameter int PDL_STD_CYC = `SWS_PDL_STD_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Open-drain line
  input  wire logic        line_in,
  output var  logic        line_out,
  output var  logic        line_oe,
  // Speed control
  input  wire logic        fast_speed_set,
  output var  logic        fast_speed_flag,
  // Bit and byte stream
  input  wire logic        tx_en,
  input  wire logic        tx_bit,
  output var  logic        rx_bit_valid,
  output var  logic        rx_bit,
  output var  logic        rx_byte_valid,
  output var  logic [7:0]  rx_byte,
  output var  logic        reset_done,
  // CRC control and results
  input  wire logic        crc_clear,
  input  wire logic        crc_en,
  output var  logic [7:0]  crc8,
  output var  logic [15:0] crc16,
  output var  logic [15:0] crc16_inv
);

  localparam int TW = `SWS_TIMER_W;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [TW-1:0] sel(input logic od, input int fast,
                                        input int std);
    sel = od ? TW'(fast) : TW'(std);
  endfunction : sel

  function automatic logic [7:0] crc8_step(input logic [7:0] c,
                                           input logic b);
    crc8_step = (c[0] ^ b) ? ((c >> 1) ^ `SWS_CRC8_POLY) : (c >> 1);
  endfunction : crc8_step

  function automatic logic [15:0] crc16_step(input logic [15:0] c,
                                             input logic b);
    crc16_step = (c[0] ^ b) ? ((c >> 1) ^ `SWS_CRC16_POLY) : (c >> 1);
  endfunction : crc16_step

  ////////////////////////////////////////////////////////////////////////////
  // Line synchroniser
  logic sync1;
  logic sync2;
  logic next_sync1;
  logic next_sync2;

  always_comb begin
    next_sync1 = line_in;
    next_sync2 = sync1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot state machine
  sws_state_t    state;
  sws_state_t    next_state;
  logic [TW-1:0] timer;
  logic [TW-1:0] next_timer;
  logic          drive;
  logic          next_drive;
  logic [2:0]    bit_cnt;
  logic [2:0]    next_bit_cnt;
  logic [7:0]    shreg;
  logic [7:0]    next_shreg;
  logic          next_line_oe;
  logic          next_fast;
  logic          next_rx_bit_valid;
  logic          next_rx_bit;
  logic          next_rx_byte_valid;
  logic [7:0]    next_rx_byte;
  logic          next_reset_done;
  logic [TW-1:0] filt_cyc;
  logic [TW-1:0] rst_cyc;

  always_comb begin
    next_state         = state;
    next_timer         = timer;
    next_drive         = drive;
    next_bit_cnt       = bit_cnt;
    next_shreg         = shreg;
    next_line_oe       = 1'b0;
    next_fast          = fast_speed_flag;
    next_rx_bit_valid  = 1'b0;
    next_rx_bit        = rx_bit;
    next_rx_byte_valid = 1'b0;
    next_rx_byte       = rx_byte;
    next_reset_done    = 1'b0;
    filt_cyc = sel(fast_speed_flag, 1, `SWS_FILT_STD_CYC);
    rst_cyc  = sel(fast_speed_flag, RST_OD_CYC, RST_STD_CYC);
    if (fast_speed_set) begin
      next_fast = 1'b1;
    end
    case (state)
      SWS_IDLE: begin
        if (!sync2) begin
          next_timer = timer + TW'(1);
          if (next_timer >= filt_cyc) begin
            next_state = SWS_LOW;
            next_drive = tx_en & ~tx_bit;
            next_line_oe = tx_en & ~tx_bit;
          end
        end else begin
          next_timer = '0;
        end
      end
      SWS_LOW: begin
        if (timer != '1) begin
          next_timer = timer + TW'(1);
        end
        next_line_oe = drive &&
          (timer < sel(fast_speed_flag, `SWS_HOLD_OD_CYC,
                       `SWS_HOLD_STD_CYC) - TW'(1));
        if (timer == sel(fast_speed_flag, `SWS_SAMP_OD_CYC,
                         `SWS_SAMP_STD_CYC)) begin
          next_rx_bit_valid = 1'b1;
          next_rx_bit       = sync2;
          next_shreg        = {sync2, shreg[7:1]};
          next_bit_cnt      = bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            next_rx_byte_valid = 1'b1;
            next_rx_byte       = {sync2, shreg[7:1]};
          end
        end
        if (sync2 && !line_oe && timer > sel(fast_speed_flag,
            `SWS_SAMP_OD_CYC, `SWS_SAMP_STD_CYC)) begin
          next_timer = '0;
          if (timer >= rst_cyc) begin
            next_state   = SWS_PD_WAIT;
            next_bit_cnt = 3'h0;
            next_drive   = 1'b0;
            if (timer >= TW'(OD_EXIT_CYC)) begin
              next_fast = 1'b0;
            end
          end else begin
            next_state = SWS_HOLDOFF;
          end
        end
      end
      SWS_PD_WAIT: begin
        next_timer = timer + TW'(1);
        if (next_timer >= sel(fast_speed_flag, `SWS_PDH_OD_CYC,
                              `SWS_PDH_STD_CYC)) begin
          next_state   = SWS_PD_LOW;
          next_timer   = '0;
          next_line_oe = 1'b1;
        end
      end
      SWS_PD_LOW: begin
        next_timer   = timer + TW'(1);
        next_line_oe = 1'b1;
        if (next_timer >= sel(fast_speed_flag, `SWS_PDL_OD_CYC,
                              PDL_STD_CYC)) begin
          next_state      = SWS_HOLDOFF;
          next_timer      = '0;
          next_line_oe    = 1'b0;
          next_reset_done = 1'b1;
        end
      end
      SWS_HOLDOFF: begin
        next_timer = timer + TW'(1);
        if (next_timer >= sel(fast_speed_flag, `SWS_REH_OD_CYC,
                              `SWS_REH_STD_CYC)) begin
          next_state = SWS_IDLE;
          next_timer = '0;
        end
      end
      default: begin
        next_state = SWS_IDLE;
        next_timer = '0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state           <= SWS_IDLE;
      timer           <= '0;
      drive           <= 1'b0;
      bit_cnt         <= 3'h0;
      shreg           <= 8'h00;
      line_oe         <= 1'b0;
      line_out        <= 1'b0;
      fast_speed_flag <= 1'b0;
      rx_bit_valid    <= 1'b0;
      rx_bit          <= 1'b0;
      rx_byte_valid   <= 1'b0;
      rx_byte         <= 8'h00;
      reset_done      <= 1'b0;
    end else begin
      state           <= next_state;
      timer           <= next_timer;
      drive           <= next_drive;
      bit_cnt         <= next_bit_cnt;
      shreg           <= next_shreg;
      line_oe         <= next_line_oe;
      line_out        <= 1'b0;
      fast_speed_flag <= next_fast;
      rx_bit_valid    <= next_rx_bit_valid;
      rx_bit          <= next_rx_bit;
      rx_byte_valid   <= next_rx_byte_valid;
      rx_byte         <= next_rx_byte;
      reset_done      <= next_reset_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CRC generators, fed with every sampled bit while enabled
  logic [7:0]  next_crc8;
  logic [15:0] next_crc16;
  logic [7:0]  base8;
  logic [15:0] base16;

  always_comb begin
    base8  = crc_clear ? `SWS_CRC8_INIT : crc8;
    base16 = crc_clear ? `SWS_CRC16_INIT : crc16;
    next_crc8  = base8;
    next_crc16 = base16;
    if (next_rx_bit_valid && crc_en) begin
      next_crc8  = crc8_step(base8, next_rx_bit);
      next_crc16 = crc16_step(base16, next_rx_bit);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      crc8      <= `SWS_CRC8_INIT;
      crc16     <= `SWS_CRC16_INIT;
      crc16_inv <= ~`SWS_CRC16_INIT;
    end else begin
      crc8      <= next_crc8;
      crc16     <= next_crc16;
      crc16_inv <= ~next_crc16;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_PD_AFTER_WAIT: assert property (
    (state == SWS_PD_LOW) && $past(state) == SWS_PD_WAIT |-> line_oe)
    else $error("presence pulse not driven after wait");

  AST_PD_ONLY_AFTER_RESET: assert property (
    $rose(line_oe) |-> $past(state) == SWS_PD_WAIT ||
                       $past(state) == SWS_IDLE)
    else $error("line driven outside presence or read slot");

  AST_OD_EXIT: assert property (
    state == SWS_LOW && sync2 && !line_oe && timer >= TW'(OD_EXIT_CYC)
    |=> !fast_speed_flag)
    else $error("long reset did not leave fast speed");

  AST_OD_KEEP: assert property (
    fast_speed_flag && state == SWS_LOW && sync2 && !line_oe &&
    timer < TW'(OD_EXIT_CYC) |=> fast_speed_flag)
    else $error("short reset left fast speed");

  AST_NO_DRIVE_ONE: assert property (
    state == SWS_LOW && !drive |-> !line_oe)
    else $error("read one pulled the line low");

  AST_HOLDOFF_IGNORE: assert property (
    state == SWS_HOLDOFF |=> state == SWS_HOLDOFF || state == SWS_IDLE)
    else $error("glitch acted on during holdoff");

  AST_FILTER_STD: assert property (
    !fast_speed_flag && state == SWS_IDLE && sync2 ##1
    state == SWS_LOW |-> 1'b0)
    else $error("slot started without filtering");

  AST_ABORT_CLEARS: assert property (
    state == SWS_LOW ##1 state == SWS_PD_WAIT |-> bit_cnt == 3'h0)
    else $error("reset did not abort byte assembly");

  AST_CRC_INV: assert property (
    crc16_inv == ~crc16)
    else $error("sent crc not inverted");

  AST_ONE_BIT_SLOT: assert property (
    rx_bit_valid |-> !$past(rx_bit_valid))
    else $error("two bits in one slot");

  COV_RESET: cover property (state == SWS_PD_LOW ##1 reset_done);
  COV_BYTE: cover property (rx_byte_valid);
  COV_OD_EXIT: cover property ($fell(fast_speed_flag));
  COV_READ0: cover property (state == SWS_LOW && line_oe);

endmodule : sws_slave
`default_nettype wire

// ### rtl/sws_regs.svh
`ifndef SWS_REGS_SVH
`define SWS_REGS_SVH

// Clock period in ns
`define SWS_CLK_NS          4

// Times in ns
`define SWS_RST_STD_NS      440000
`define SWS_RST_OD_NS       48000
`define SWS_OD_EXIT_NS      690000
`define SWS_OD_KEEP_NS      80000
`define SWS_PDH_STD_NS      15000
`define SWS_PDH_OD_NS       2000
`define SWS_PDL_STD_NS      60000
`define SWS_PDL_OD_NS       8000
`define SWS_SAMP_STD_NS     30000
`define SWS_SAMP_OD_NS      3000
`define SWS_HOLD_STD_NS     30000
`define SWS_HOLD_OD_NS      3000
`define SWS_REH_STD_NS      1000
`define SWS_REH_OD_NS       300
`define SWS_FILT_STD_NS     40

// Least times round up, all counts at least one cycle
`define SWS_CYC(t)          (((t) + `SWS_CLK_NS - 1) / `SWS_CLK_NS)
`define SWS_RST_STD_CYC     `SWS_CYC(`SWS_RST_STD_NS)
`define SWS_RST_OD_CYC      `SWS_CYC(`SWS_RST_OD_NS)
`define SWS_OD_EXIT_CYC     `SWS_CYC(`SWS_OD_EXIT_NS)
`define SWS_PDH_STD_CYC     `SWS_CYC(`SWS_PDH_STD_NS)
`define SWS_PDH_OD_CYC      `SWS_CYC(`SWS_PDH_OD_NS)
`define SWS_PDL_STD_CYC     `SWS_CYC(`SWS_PDL_STD_NS)
`define SWS_PDL_OD_CYC      `SWS_CYC(`SWS_PDL_OD_NS)
`define SWS_SAMP_STD_CYC    `SWS_CYC(`SWS_SAMP_STD_NS)
`define SWS_SAMP_OD_CYC     `SWS_CYC(`SWS_SAMP_OD_NS)
`define SWS_HOLD_STD_CYC    `SWS_CYC(`SWS_HOLD_STD_NS)
`define SWS_HOLD_OD_CYC     `SWS_CYC(`SWS_HOLD_OD_NS)
`define SWS_REH_STD_CYC     `SWS_CYC(`SWS_REH_STD_NS)
`define SWS_REH_OD_CYC      `SWS_CYC(`SWS_REH_OD_NS)
`define SWS_FILT_STD_CYC    `SWS_CYC(`SWS_FILT_STD_NS)

// CRC layout, reflected polynomials for LSB-first shifting
`define SWS_CRC8_POLY       8'h8c
`define SWS_CRC16_POLY      16'ha001
`define SWS_CRC8_INIT       8'h00
`define SWS_CRC16_INIT      16'h0000
`define SWS_TIMER_W         18

`endif

// ### rtl/sws_pkg.sv
package sws_pkg;

  typedef enum logic [2:0] {
    SWS_IDLE,
    SWS_LOW,
    SWS_PD_WAIT,
    SWS_PD_LOW,
    SWS_HOLDOFF
  } sws_state_t;

endpackage : sws_pkg

// ### bench/sws_master.sv
`timescale 1ns/100ps
`default_nettype none

module sws_master (
  // Clock
  input  wire logic clk,
  // Resolved line and master pulldown
  input  wire logic line,
  output var  logic pull
);

  initial pull = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Master pulls low for n cycles, then releases to the pull-up
  task automatic hold_low(input int n);
    pull = 1'b1;
    repeat (n) @(negedge clk);
    pull = 1'b0;
  endtask : hold_low

  // Write slot, then recovery before the next one
  task automatic write_bit(input logic b, input logic od);
    int lo;
    lo = od ? 800 : 7600;
    hold_low(b ? 20 : lo);
    repeat ((b ? lo - 20 : 0) + (od ? 100 : 300)) @(negedge clk);
  endtask : write_bit

  // Overdrive read slot: short pulse, sample in window, wait out slot
  task automatic read_bit(output logic b);
    hold_low(5);
    repeat (300) @(negedge clk);
    b = line;
    repeat (750) @(negedge clk);
  endtask : read_bit

endmodule : sws_master
`default_nettype wire

// ### bench/test_single_wire_slave_signaling_crc.sv
`timescale 1ns/100ps
`default_nettype none
`include "sws_regs.svh"

module test_single_wire_slave_signaling_crc;

  typedef struct packed {
    logic [7:0] din;
    logic [7:0] dout;
  } sws_row_t;

  logic        clk;
  logic        reset;
  logic        fast_speed_set;
  logic        tx_en;
  logic        tx_bit;
  logic        crc_clear;
  logic        crc_en;
  logic        pull;
  wire  logic  line;
  logic        line_oe;
  logic        line_out;
  logic        fast_speed_flag;
  logic        rx_bit_valid;
  logic        rx_bit;
  logic        rx_byte_valid;
  logic [7:0]  rx_byte;
  logic        reset_done;
  logic [7:0]  crc8;
  logic [15:0] crc16;
  logic [15:0] crc16_inv;
  int          n_fail;
  int          checks;
  int          n_rx;
  int          n_byte;
  int          n_done;
  logic        rx_last;
  logic [7:0]  byte_last;
  sws_row_t    rows [3] = '{'{8'ha5, 8'ha5}, '{8'h00, 8'h00},
                            '{8'h3c, 8'h3c}};

  // Open-drain line with pull-up
  assign line = ~(pull | line_oe);

  sws_slave #(
    .RST_STD_CYC (8000),
    .OD_EXIT_CYC (12500),
    .PDL_STD_CYC (50)
  ) i_sws_slave (
    .clk (clk), .reset (reset), .line_in (line), .line_out (line_out),
    .line_oe (line_oe), .fast_speed_set (fast_speed_set),
    .fast_speed_flag (fast_speed_flag), .tx_en (tx_en), .tx_bit (tx_bit),
    .rx_bit_valid (rx_bit_valid), .rx_bit (rx_bit),
    .rx_byte_valid (rx_byte_valid), .rx_byte (rx_byte),
    .reset_done (reset_done), .crc_clear (crc_clear), .crc_en (crc_en),
    .crc8 (crc8), .crc16 (crc16), .crc16_inv (crc16_inv)
  );

  sws_master i_sws_master (.clk (clk), .line (line), .pull (pull));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rx_bit_valid === 1'b1) begin
      n_rx    <= n_rx + 1;
      rx_last <= rx_bit;
    end
    if (rx_byte_valid === 1'b1) begin
      n_byte    <= n_byte + 1;
      byte_last <= rx_byte;
    end
    if (reset_done === 1'b1) n_done <= n_done + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk

  task automatic give_verdict;
    $display("fails %0d checks %0d", n_fail, checks);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // Reset pulse, then measure presence wait and length
  task automatic rst_pres(input int lo, input int ew, input int el);
    int w;
    int l;
    int d;
    d = n_done;
    w = 0;
    l = 0;
    i_sws_master.hold_low(lo);
    while (line_oe !== 1'b1 && w < ew + 100) begin
      @(negedge clk);
      w++;
    end
    chk(w >= ew - 2 && w <= ew + 15, "presence wait");
    while (line_oe === 1'b1 && l < el + 100) begin
      @(negedge clk);
      l++;
    end
    chk(l >= el - 2 && l <= el + 2, "presence low");
    repeat (300) @(negedge clk);
    chk(n_done == d + 1, "presence done");
  endtask : rst_pres

  task automatic wr_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) i_sws_master.write_bit(b[i], 1'b1);
  endtask : wr_byte

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] c16;
    logic [7:0]  c8;
    logic        b;
    logic        fb;
    int          nr;
    reset = 1'b1;
    {fast_speed_set, tx_en, tx_bit, crc_clear, crc_en} = 5'h00;
    {n_fail, checks, n_rx, n_byte, n_done} = '0;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    chk(line_oe === 1'b0 && fast_speed_flag === 1'b0 && line_out === 1'b0,
        "reset outputs");
    chk(crc16_inv === 16'hffff && crc8 === 8'h00, "reset crc");
    nr = n_rx;
    i_sws_master.write_bit(1'b0, 1'b0);
    chk(n_rx == nr + 1 && rx_last === 1'b0, "std write zero");
    i_sws_master.hold_low(5);
    repeat (8000) @(negedge clk);
    chk(n_rx == nr + 1, "std short low");
    rst_pres(8100, 3750, 50);
    fast_speed_set = 1'b1;
    @(negedge clk);
    fast_speed_set = 1'b0;
    @(negedge clk);
    chk(fast_speed_flag === 1'b1, "overdrive set");
    crc_clear = 1'b1;
    @(negedge clk);
    crc_clear = 1'b0;
    crc_en = 1'b1;
    c16 = 16'h0000;
    c8 = 8'h00;
    foreach (rows[i]) begin
      wr_byte(rows[i].din);
      chk(byte_last === rows[i].dout, "rx byte");
      for (int j = 0; j < 8; j++) begin
        fb = c16[0] ^ rows[i].din[j];
        c16 = fb ? ((c16 >> 1) ^ `SWS_CRC16_POLY) : (c16 >> 1);
        fb = c8[0] ^ rows[i].din[j];
        c8 = fb ? ((c8 >> 1) ^ `SWS_CRC8_POLY) : (c8 >> 1);
      end
    end
    crc_en = 1'b0;
    @(negedge clk);
    chk(crc16 === c16 && crc16_inv === ~c16, "crc16");
    chk(crc8 === c8, "crc8");
    tx_en = 1'b1;
    for (int v = 0; v < 2; v++) begin
      tx_bit = v[0];
      i_sws_master.read_bit(b);
      chk(b === v[0], "read bit");
    end
    tx_en = 1'b0;
    nr = n_rx;
    i_sws_master.hold_low(1000);
    repeat (20) @(negedge clk);
    i_sws_master.hold_low(20);
    repeat (1000) @(negedge clk);
    chk(n_rx == nr + 1, "holdoff glitch");
    rst_pres(12100, 500, 2000);
    chk(fast_speed_flag === 1'b1, "overdrive kept");
    for (int i = 0; i < 3; i++) i_sws_master.write_bit(1'b1, 1'b1);
    rst_pres(12100, 500, 2000);
    nr = n_byte;
    wr_byte(8'h96);
    chk(n_byte == nr + 1 && byte_last === 8'h96, "restart byte");
    rst_pres(12600, 3750, 50);
    chk(fast_speed_flag === 1'b0, "overdrive left");
    give_verdict;
  end

  initial begin
    #600000;
    n_fail++;
    give_verdict;
  end

endmodule : test_single_wire_slave_signaling_crc
`default_nettype wire
